// [design/phy_access_pkg.sv]
package phy_access_pkg;

  // Register bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h0EC;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h1F0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 12'h1F4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 12'h1F8;

  // Control register field positions
  localparam int BIT_DONE = 31;
  localparam int RSVD_HI_MSB = 30;
  localparam int RSVD_HI_LSB = 28;
  localparam int RX_ADDR_MSB = 27;
  localparam int RX_ADDR_LSB = 24;
  localparam int RX_VALUE_MSB = 23;
  localparam int RX_VALUE_LSB = 16;
  localparam int BIT_READ_REQ = 15;
  localparam int BIT_WRITE_REQ = 14;
  localparam int RSVD_LO_MSB = 13;
  localparam int RSVD_LO_LSB = 12;
  localparam int TGT_ADDR_MSB = 11;
  localparam int TGT_ADDR_LSB = 8;
  localparam int WR_VALUE_MSB = 7;
  localparam int WR_VALUE_LSB = 0;

  // Field widths
  localparam int REG_ADDR_W = 4;
  localparam int REG_VALUE_W = 8;

  // Reset values
  localparam logic [REG_ADDR_W-1:0] TGT_ADDR_RST = 4'h0;
  localparam logic [REG_VALUE_W-1:0] WR_VALUE_RST = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE = 32'h0000_0000;

  // Interrupt status layout
  localparam int IRQ_W = 2;
  localparam int IRQ_XFER_DONE = 0;
  localparam int IRQ_REQ_SENT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  typedef enum logic {
    REQ_IDLE,
    REQ_SEND
  } req_state_e;

endpackage

// [design/phy_register_access.sv]
// Chosen here: strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Done flag clears when software sets the read or write request bit.
// - Done flag sets when a register transfer arrives from the PHY.
// - Control bits 30 to 28 read as zero.
// - Bits 27 to 24 hold address of the latest PHY register transfer.
// - Bits 23 to 16 hold register contents returned by the PHY.
// - Software sets bit 15 to read; hardware clears it once request sent.
// - Software sets bit 14 to write; hardware clears it once request sent.
// - Control bits 13 and 12 read as zero.
// - Bits 11 to 8 select the PHY register, read/write, reset zero.
// - Bits 7 to 0 hold the write value, reset zero, unused on reads.
module phy_register_access (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [phy_access_pkg::ADDR_W-1:0] ADDR,
  input wire logic [phy_access_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [phy_access_pkg::DATA_W-1:0] RDATA,
  output logic PHY_REQ_VALID,
  output logic PHY_REQ_WRITE,
  output logic [phy_access_pkg::REG_ADDR_W-1:0] PHY_REQ_ADDR,
  output logic [phy_access_pkg::REG_VALUE_W-1:0] PHY_REQ_DATA,
  input wire logic PHY_REQ_READY,
  input wire logic PHY_XFER_VALID,
  input wire logic [phy_access_pkg::REG_ADDR_W-1:0] PHY_XFER_ADDR,
  input wire logic [phy_access_pkg::REG_VALUE_W-1:0] PHY_XFER_DATA,
  output logic IRQ
);
  import phy_access_pkg::*;

  // Control register state
  logic phy_xfer_done_flag_reg;
  logic phy_xfer_done_flag_next;
  logic [REG_ADDR_W-1:0] received_reg_addr_reg;
  logic [REG_VALUE_W-1:0] received_reg_value_reg;
  logic read_request_bit_reg;
  logic read_request_bit_next;
  logic write_request_bit_reg;
  logic write_request_bit_next;
  logic [REG_ADDR_W-1:0] target_reg_addr_reg;
  logic [REG_ADDR_W-1:0] target_reg_addr_next;
  logic [REG_VALUE_W-1:0] write_value_reg;
  logic [REG_VALUE_W-1:0] write_value_next;

  // Request sequencer state
  req_state_e state_reg;
  req_state_e state_next;
  logic req_valid_reg;
  logic req_write_reg;
  logic [REG_ADDR_W-1:0] req_addr_reg;
  logic [REG_VALUE_W-1:0] req_data_reg;

  // Interrupt state
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_status_next;
  logic [IRQ_W-1:0] irq_enable_reg;
  logic [IRQ_W-1:0] irq_enable_next;
  logic irq_reg;

  // Read data
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // Address decode
  wire sel_control = (ADDR == OFS_CONTROL);
  wire sel_status = (ADDR == OFS_IRQ_STATUS);
  wire sel_clear = (ADDR == OFS_IRQ_CLEAR);
  wire sel_enable = (ADDR == OFS_IRQ_ENABLE);
  wire wr_control = WR && sel_control;
  wire wr_clear = WR && sel_clear;
  wire wr_enable = WR && sel_enable;

  // Software request writes
  wire sw_set_read = wr_control && WDATA[BIT_READ_REQ];
  wire sw_set_write = wr_control && WDATA[BIT_WRITE_REQ];
  wire sw_set_any = sw_set_read || sw_set_write;

  // Request handshake events
  wire launch = (state_reg == REQ_IDLE) && (read_request_bit_reg || write_request_bit_reg);
  wire launch_write = !read_request_bit_reg;
  wire accepted = (state_reg == REQ_SEND) && req_valid_reg && PHY_REQ_READY;
  wire sent_read = accepted && !req_write_reg;
  wire sent_write = accepted && req_write_reg;

  // Control register image; reserved bits tie to zero
  wire [DATA_W-1:0] control_image = {
    phy_xfer_done_flag_reg,
    3'b000,
    received_reg_addr_reg,
    received_reg_value_reg,
    read_request_bit_reg,
    write_request_bit_reg,
    2'b00,
    target_reg_addr_reg,
    write_value_reg
  };

  wire [DATA_W-1:0] status_image = {{(DATA_W-IRQ_W){1'b0}}, irq_status_reg};
  wire [DATA_W-1:0] enable_image = {{(DATA_W-IRQ_W){1'b0}}, irq_enable_reg};

  // Read mux; clear register and unmapped addresses read zero
  wire [DATA_W-1:0] read_mux =
    sel_control ? control_image :
    sel_status ? status_image :
    sel_enable ? enable_image :
    READ_IDLE;

  // Interrupt events
  wire [IRQ_W-1:0] irq_events = {accepted, PHY_XFER_VALID};

  // Next-state logic
  always_comb begin
    // Arrival wins over a software clear in the same cycle
    phy_xfer_done_flag_next = phy_xfer_done_flag_reg;
    if (sw_set_any) begin
      phy_xfer_done_flag_next = 1'b0;
    end
    if (PHY_XFER_VALID) begin
      phy_xfer_done_flag_next = 1'b1;
    end

    // A software set in the clearing cycle wins
    read_request_bit_next = read_request_bit_reg;
    if (sent_read) begin
      read_request_bit_next = 1'b0;
    end
    if (sw_set_read) begin
      read_request_bit_next = 1'b1;
    end

    write_request_bit_next = write_request_bit_reg;
    if (sent_write) begin
      write_request_bit_next = 1'b0;
    end
    if (sw_set_write) begin
      write_request_bit_next = 1'b1;
    end

    target_reg_addr_next = target_reg_addr_reg;
    write_value_next = write_value_reg;
    if (wr_control) begin
      target_reg_addr_next = WDATA[TGT_ADDR_MSB:TGT_ADDR_LSB];
      write_value_next = WDATA[WR_VALUE_MSB:WR_VALUE_LSB];
    end

    irq_status_next = irq_status_reg;
    if (wr_clear) begin
      irq_status_next = irq_status_reg & ~WDATA[IRQ_W-1:0];
    end
    irq_status_next = irq_status_next | irq_events;

    irq_enable_next = irq_enable_reg;
    if (wr_enable) begin
      irq_enable_next = WDATA[IRQ_W-1:0];
    end

    rdata_next = RD ? read_mux : READ_IDLE;
  end

  // Sequencer: one request per set bit, held until taken
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      REQ_IDLE: begin
        if (launch) begin
          state_next = REQ_SEND;
        end
      end
      REQ_SEND: begin
        if (accepted) begin
          state_next = REQ_IDLE;
        end
      end
      default: begin
        state_next = REQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= REQ_IDLE;
      req_valid_reg <= 1'b0;
      req_write_reg <= 1'b0;
      req_addr_reg <= TGT_ADDR_RST;
      req_data_reg <= WR_VALUE_RST;
    end else begin
      state_reg <= state_next;
      if (launch) begin
        // Read takes priority if both bits are ever set
        req_valid_reg <= 1'b1;
        req_write_reg <= launch_write;
        req_addr_reg <= target_reg_addr_reg;
        req_data_reg <= launch_write ? write_value_reg : WR_VALUE_RST;
      end else if (accepted) begin
        req_valid_reg <= 1'b0;
      end
    end
  end

  // Control register
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      phy_xfer_done_flag_reg <= 1'b0;
      read_request_bit_reg <= 1'b0;
      write_request_bit_reg <= 1'b0;
      target_reg_addr_reg <= TGT_ADDR_RST;
      write_value_reg <= WR_VALUE_RST;
    end else begin
      phy_xfer_done_flag_reg <= phy_xfer_done_flag_next;
      read_request_bit_reg <= read_request_bit_next;
      write_request_bit_reg <= write_request_bit_next;
      target_reg_addr_reg <= target_reg_addr_next;
      write_value_reg <= write_value_next;
    end
  end

  // Captured PHY transfer
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      received_reg_addr_reg <= TGT_ADDR_RST;
      received_reg_value_reg <= WR_VALUE_RST;
    end else if (PHY_XFER_VALID) begin
      received_reg_addr_reg <= PHY_XFER_ADDR;
      received_reg_value_reg <= PHY_XFER_DATA;
    end
  end

  // Interrupts and read data
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_status_reg <= IRQ_RST;
      irq_enable_reg <= IRQ_RST;
      irq_reg <= 1'b0;
      rdata_reg <= READ_IDLE;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_enable_reg <= irq_enable_next;
      irq_reg <= |(irq_status_next & irq_enable_next);
      rdata_reg <= rdata_next;
    end
  end

  assign RDATA = rdata_reg;
  assign PHY_REQ_VALID = req_valid_reg;
  assign PHY_REQ_WRITE = req_write_reg;
  assign PHY_REQ_ADDR = req_addr_reg;
  assign PHY_REQ_DATA = req_data_reg;
  assign IRQ = irq_reg;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence seq_read_ctrl;
    RD && sel_control;
  endsequence

  sequence seq_offer;
    PHY_REQ_VALID && !PHY_REQ_READY;
  endsequence

  sequence seq_taken;
    PHY_REQ_VALID && PHY_REQ_READY;
  endsequence

  chk_done_clear: assert property (
    (sw_set_any && !PHY_XFER_VALID) |=> !phy_xfer_done_flag_reg)
    else $error("done flag not cleared by request");

  chk_done_set: assert property (
    PHY_XFER_VALID |=> phy_xfer_done_flag_reg)
    else $error("done flag not set by PHY transfer");

  chk_rsvd_high: assert property (
    seq_read_ctrl |=> RDATA[RSVD_HI_MSB:RSVD_HI_LSB] == 3'b000)
    else $error("reserved high bits not zero");

  chk_rx_addr: assert property (
    PHY_XFER_VALID ##1 seq_read_ctrl |=>
      RDATA[RX_ADDR_MSB:RX_ADDR_LSB] == $past(PHY_XFER_ADDR, 2))
    else $error("received address not captured");

  chk_rx_value: assert property (
    PHY_XFER_VALID |=> received_reg_value_reg == $past(PHY_XFER_DATA))
    else $error("received value not captured");

  chk_read_clear: assert property (
    (sent_read && !sw_set_read) |=> !read_request_bit_reg && !PHY_REQ_VALID)
    else $error("read request bit not cleared after send");

  chk_write_clear: assert property (
    (sent_write && !sw_set_write) |=> !write_request_bit_reg)
    else $error("write request bit not cleared after send");

  chk_rsvd_low: assert property (
    seq_read_ctrl |=> RDATA[RSVD_LO_MSB:RSVD_LO_LSB] == 2'b00)
    else $error("reserved low bits not zero");

  chk_field_store: assert property (
    wr_control |=> target_reg_addr_reg == $past(WDATA[TGT_ADDR_MSB:TGT_ADDR_LSB])
      && write_value_reg == $past(WDATA[WR_VALUE_MSB:WR_VALUE_LSB]))
    else $error("target address or write value not stored");

  chk_req_launch: assert property (
    (state_reg == REQ_IDLE && read_request_bit_reg) |=>
      PHY_REQ_VALID && !PHY_REQ_WRITE && PHY_REQ_ADDR == $past(target_reg_addr_reg))
    else $error("read request not issued");

  chk_req_hold: assert property (
    seq_offer |=> PHY_REQ_VALID && $stable(PHY_REQ_ADDR) && $stable(PHY_REQ_DATA))
    else $error("request dropped before taken");

  chk_req_single: assert property (
    seq_taken |=> !PHY_REQ_VALID)
    else $error("request repeated after acceptance");

  chk_write_launch: assert property (
    (state_reg == REQ_IDLE && write_request_bit_reg && !read_request_bit_reg) |=>
      PHY_REQ_VALID && PHY_REQ_WRITE && PHY_REQ_DATA == $past(write_value_reg))
    else $error("write request not issued");

  chk_rdata_idle: assert property (
    !RD |=> RDATA == READ_IDLE)
    else $error("read data not idle after no read");

  chk_status_xfer: assert property (
    PHY_XFER_VALID |=> irq_status_reg[IRQ_XFER_DONE])
    else $error("transfer status bit not set");

  chk_status_sent: assert property (
    accepted |=> irq_status_reg[IRQ_REQ_SENT])
    else $error("request sent status bit not set");

  chk_irq_level: assert property (
    IRQ == |(irq_status_reg & irq_enable_reg))
    else $error("interrupt output mismatch");

endmodule

`default_nettype wire

// [testbench/phy_layer_model.sv]
`timescale 1ns/100ps
`default_nettype none
module phy_layer_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [phy_access_pkg::REG_ADDR_W-1:0] req_addr,
  input wire logic [phy_access_pkg::REG_VALUE_W-1:0] req_data,
  input wire logic [phy_access_pkg::REG_ADDR_W-1:0] lag,
  output logic req_ready,
  output logic xfer_valid,
  output logic [phy_access_pkg::REG_ADDR_W-1:0] xfer_addr,
  output logic [phy_access_pkg::REG_VALUE_W-1:0] xfer_data,
  output int accepted
);
  import phy_access_pkg::*;
  logic [REG_VALUE_W-1:0] regs [16];
  logic [REG_ADDR_W-1:0] wait_cnt;
  // Accept once the request has waited the programmed lag
  assign req_ready = req_valid && (wait_cnt == lag);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_cnt <= '0;
      xfer_valid <= 1'b0;
      xfer_addr <= '0;
      xfer_data <= '0;
      accepted <= 0;
      for (int i = 0; i < 16; i++) regs[i] <= {4'hA, 4'(i)};
    end else begin
      wait_cnt <= (req_valid && !req_ready) ? wait_cnt + 4'h1 : 4'h0;
      // A read answers with one transfer the cycle after acceptance
      xfer_valid <= req_ready && !req_write;
      // Released lines toggle so stale values never look valid
      xfer_addr <= req_ready ? req_addr : ~xfer_addr;
      xfer_data <= req_ready ? regs[req_addr] : ~xfer_data;
      if (req_ready) accepted <= accepted + 1;
      if (req_ready && req_write) regs[req_addr] <= req_data;
    end
  end
endmodule
`default_nettype wire

// [testbench/phy_register_access_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module phy_register_access_tb;
  import phy_access_pkg::*;
  logic CLK, RSTN, WR, RD, req_valid, req_write, req_ready, xfer_valid, IRQ;
  logic [ADDR_W-1:0] ADDR;
  logic [DATA_W-1:0] WDATA, RDATA, v;
  logic [REG_ADDR_W-1:0] req_addr, xfer_addr, lag;
  logic [REG_VALUE_W-1:0] req_data, xfer_data;
  int accepted, num_errors, samples_checked, n0;
  phy_register_access uut (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .PHY_REQ_VALID(req_valid), .PHY_REQ_WRITE(req_write),
    .PHY_REQ_ADDR(req_addr), .PHY_REQ_DATA(req_data), .PHY_REQ_READY(req_ready),
    .PHY_XFER_VALID(xfer_valid), .PHY_XFER_ADDR(xfer_addr), .PHY_XFER_DATA(xfer_data),
    .IRQ(IRQ));
  phy_layer_model phy (.clk(CLK), .rstn(RSTN), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_data(req_data), .lag(lag), .req_ready(req_ready),
    .xfer_valid(xfer_valid), .xfer_addr(xfer_addr), .xfer_data(xfer_data),
    .accepted(accepted));
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  task automatic chk(input string name, input logic [DATA_W-1:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  // Poll the control register until bit b reaches val, bounded
  task automatic wait_bit(input int b, input logic val);
    rd(OFS_CONTROL);
    for (int i = 0; i < 40 && v[b] !== val; i++) rd(OFS_CONTROL);
  endtask
  task automatic close_out;
    if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    num_errors++;
    close_out();
  end
  initial begin
    RSTN = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = '0;
    WDATA = '0;
    lag = '0;
    repeat (20) @(posedge CLK);
    RSTN <= 1'b1;
    rd(OFS_CONTROL);
    chk("ctrl reset", 32'h0000_0000, v);
    rd(12'h0F0);
    chk("unmapped", 32'h0000_0000, v);
    wr(OFS_IRQ_ENABLE, 32'h0000_0003);
    // Read request, prompt PHY
    n0 = accepted;
    wr(OFS_CONTROL, 32'h0000_8235);
    rd(OFS_CONTROL);
    chk("read req set", 32'h0000_8235, v);
    wait_bit(31, 1'b1);
    chk("read done", 32'h82A2_0235, v);
    chk("read count", 32'h0000_0001, 32'(accepted - n0));
    chk("irq on", 32'h0000_0001, {31'h0, IRQ});
    rd(OFS_IRQ_STATUS);
    chk("status both", 32'h0000_0003, v);
    wr(OFS_IRQ_CLEAR, 32'h0000_0001);
    wr(OFS_IRQ_STATUS, 32'h0000_0000);
    rd(OFS_IRQ_STATUS);
    chk("status cleared", 32'h0000_0002, v);
    rd(OFS_IRQ_CLEAR);
    chk("clear reads zero", 32'h0000_0000, v);
    wr(OFS_IRQ_ENABLE, 32'h0000_0001);
    @(posedge CLK);
    #1 chk("irq masked", 32'h0000_0000, {31'h0, IRQ});
    wr(OFS_IRQ_CLEAR, 32'h0000_0003);
    // Write request, slow PHY
    lag <= 4'h3;
    n0 = accepted;
    wr(OFS_CONTROL, 32'h0000_45C7);
    rd(OFS_CONTROL);
    chk("write req set", 32'h02A2_45C7, v);
    wait_bit(14, 1'b0);
    chk("write req clr", 32'h02A2_05C7, v);
    chk("write count", 32'h0000_0001, 32'(accepted - n0));
    chk("phy value", 32'h0000_00C7, {24'h0, phy.regs[5]});
    // Read back; upper and reserved bits must not take the write
    wr(OFS_CONTROL, 32'hFFFF_B5FF);
    rd(OFS_CONTROL);
    chk("rsvd bits", 32'h02A2_85FF, v);
    wait_bit(31, 1'b1);
    chk("readback", 32'h85C7_05FF, v);
    rd(OFS_IRQ_STATUS);
    chk("status again", 32'h0000_0003, v);
    chk("irq again", 32'h0000_0001, {31'h0, IRQ});
    close_out();
  end
endmodule
`default_nettype wire
